// ### clrb_ctrl.v
`timescale 1ns/1ps
`include "clrb_map.vh"
module clrb_ctrl (
  input wire CLK_SYS,
  input wire RST,
  input wire [7:0] WB_ADR_I,
  input wire [31:0] WB_DAT_I,
  output wire [31:0] WB_DAT_O,
  input wire WB_WE_I,
  input wire [3:0] WB_SEL_I,
  input wire WB_STB_I,
  input wire WB_CYC_I,
  output wire WB_ACK_O,
  output reg DDR_CK,
  output reg DDR_CK_N,
  output reg DDR_CKE,
  output reg DDR_RESET_N,
  output wire DDR_CS_N,
  output wire DDR_RAS_N,
  output wire DDR_CAS_N,
  output wire DDR_WE_N,
  output wire [2:0] DDR_BA,
  output wire [12:0] DDR_ADDR,
  input wire [15:0] DDR_DQ,
  input wire DLL_LOCKED
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ISSUE = 3'h1;
  localparam [2:0] S_WAIT = 3'h2;
  localparam [2:0] S_MRS_ON = 3'h3;
  localparam [2:0] S_DRAIN = 3'h4;
  localparam [2:0] S_MRS_OFF = 3'h5;
  localparam integer RP_I = (`CLRB_T_RP_NS + `CLRB_CK_NS - 1) / `CLRB_CK_NS;
  localparam integer RCD_I = (`CLRB_T_RCD_NS + `CLRB_CK_NS - 1) / `CLRB_CK_NS;
  localparam [7:0] T_RP_CK = (RP_I < 1) ? 8'h01 : RP_I[7:0];
  localparam [7:0] T_RCD_CK = (RCD_I < 1) ? 8'h01 : RCD_I[7:0];
  localparam [7:0] T_MODE_CK = `CLRB_T_MRD_NCK + `CLRB_T_MOD_NCK;

  wire [15:0] dq_s;
  wire dll_s;
  wire tm_done;
  wire tick;
  wire [7:0] open_w;
  reg [2:0] ph_q;
  reg ack_q;
  reg [31:0] dat_q;
  reg [31:0] addr_q;
  reg [31:0] cfg_q;
  reg [31:0] rd_mux;
  reg [2:0] st_q;
  reg [2:0] ret_q;
  reg [3:0] pcmd_q;
  reg [2:0] pba_q;
  reg [12:0] pa_q;
  reg [3:0] nxt_cmd_q;
  reg [2:0] nxt_ba_q;
  reg [12:0] nxt_a_q;
  reg [7:0] nxt_wait_q;
  reg nxt_rd_q;
  reg nxt_eight_q;
  reg mpr_q;
  reg err_q;
  reg [31:0] sr_q;
  reg [31:0] len_sr_q;
  reg on_q;
  reg cur8_q;
  reg [4:0] wc_q;
  reg [15:0] cap_q;
  reg [16:0] rdat_q;
  reg valid_q;

  // Pins from the device and the lock flag cross into this clock first.
  clrb_sync #(.W(17)) u_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .d({DLL_LOCKED, DDR_DQ}),
    .q({dll_s, dq_s})
  );

  wire iss = (st_q == S_ISSUE) && tick;
  wire iss_rd = iss && nxt_rd_q;

  clrb_tmr u_tmr (
    .clk(CLK_SYS),
    .rst(RST),
    .load(iss),
    .val(nxt_wait_q),
    .tick(tick),
    .done(tm_done)
  );

  // The command clock is an eighth of the system clock; commands change at its fall.
  wire [2:0] ph_nx = ph_q + 3'h1;
  assign tick = (ph_q == `CLRB_TICK_PH);
  always @(posedge CLK_SYS) begin
    if (RST) begin
      // Starting one phase early gives the first command-clock high phase its full length.
      ph_q <= 3'h7;
      DDR_CK <= 1'b0;
      DDR_CK_N <= 1'b1;
      DDR_CKE <= 1'b0;
      DDR_RESET_N <= 1'b0;
    end else begin
      ph_q <= ph_nx;
      DDR_CK <= ~ph_nx[2];
      DDR_CK_N <= ph_nx[2];
      DDR_CKE <= cfg_q[`CLRB_F_CKE];
      DDR_RESET_N <= cfg_q[`CLRB_F_RSTN];
    end
  end

  // Wishbone slave: every request is answered one cycle later, unmapped reads give zero.
  wire wb_req = WB_CYC_I & WB_STB_I & ~ack_q;
  wire [5:0] idx = WB_ADR_I[7:2];
  wire wb_wr = wb_req & WB_WE_I;
  wire go = wb_wr & WB_SEL_I[0] & (idx == `CLRB_IDX_CMD);
  wire [31:0] wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  wire [31:0] stat_w = {16'h0000, open_w, 2'b00, on_q | (|sr_q), valid_q, err_q, dll_s,
                        mpr_q, st_q != S_IDLE};
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

  always @* begin
    case (idx)
      `CLRB_IDX_ADDR: rd_mux = addr_q;
      `CLRB_IDX_CFG: rd_mux = cfg_q;
      `CLRB_IDX_STAT: rd_mux = stat_w;
      `CLRB_IDX_DATA: rd_mux = {15'h0000, rdat_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge CLK_SYS) begin
    if (RST) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
      addr_q <= 32'h00000000;
      cfg_q <= `CLRB_CFG_RST;
    end else begin
      ack_q <= wb_req;
      if (wb_req) begin
        dat_q <= WB_WE_I ? 32'h00000000 : rd_mux;
      end
      if (wb_wr && idx == `CLRB_IDX_ADDR) begin
        addr_q <= (addr_q & ~wmask) | (WB_DAT_I & wmask);
      end
      if (wb_wr && idx == `CLRB_IDX_CFG) begin
        cfg_q <= (cfg_q & ~wmask) | (WB_DAT_I & wmask);
      end
    end
  end

  // Burst length as the device will decide it for this command.
  wire [1:0] mr0 = cfg_q[`CLRB_F_MR0];
  wire bc = addr_q[`CLRB_F_BC];
  wire eight_now = (mr0 == `CLRB_MR0_FIXED8) || ((mr0 == `CLRB_MR0_OTF) && bc);
  wire [2:0] bank = addr_q[`CLRB_F_BANK];
  wire [12:0] rd_a = {bc, 1'b0, addr_q[`CLRB_F_AP], addr_q[`CLRB_F_COL]};
  wire [12:0] mpr_a = {bc, 9'h000, ~eight_now & addr_q[`CLRB_F_A2], 2'b00};
  wire [12:0] mr3_on = `CLRB_MR3_ON | {11'h000, addr_q[`CLRB_F_LOC]};
  wire rd_busy = on_q | (|sr_q);

  task prep;
    input [3:0] c;
    input [2:0] b;
    input [12:0] a;
    input [7:0] w;
    input r;
    input [2:0] nx;
    begin
      nxt_cmd_q <= c;
      nxt_ba_q <= b;
      nxt_a_q <= a;
      nxt_wait_q <= w;
      nxt_rd_q <= r;
      nxt_eight_q <= eight_now;
      ret_q <= nx;
      st_q <= S_ISSUE;
    end
  endtask

  always @(posedge CLK_SYS) begin
    if (RST) begin
      st_q <= S_IDLE;
      ret_q <= S_IDLE;
      pcmd_q <= `CLRB_CMD_NOP;
      pba_q <= 3'h0;
      pa_q <= 13'h0000;
      nxt_cmd_q <= `CLRB_CMD_NOP;
      nxt_ba_q <= 3'h0;
      nxt_a_q <= 13'h0000;
      nxt_wait_q <= 8'h00;
      nxt_rd_q <= 1'b0;
      nxt_eight_q <= 1'b0;
      mpr_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      if (tick) begin
        pcmd_q <= `CLRB_CMD_NOP;
      end
      if (go) begin
        err_q <= 1'b1;
      end
      case (st_q)
        S_IDLE: begin
          if (go) begin
            err_q <= 1'b0;
            case (WB_DAT_I[`CLRB_F_OP])
              `CLRB_OP_ACT: begin
                if (mpr_q || open_w[bank]) begin
                  err_q <= 1'b1;
                end else begin
                  prep(`CLRB_CMD_ACT, bank, addr_q[`CLRB_F_ROW], T_RCD_CK, 1'b0, S_IDLE);
                end
              end
              `CLRB_OP_PRE, `CLRB_OP_PREA: begin
                if (mpr_q) begin
                  err_q <= 1'b1;
                end else if (WB_DAT_I[0]) begin
                  prep(`CLRB_CMD_PRE, bank, `CLRB_A_ALLBANKS, T_RP_CK, 1'b0, S_IDLE);
                end else begin
                  prep(`CLRB_CMD_PRE, bank, 13'h0000, T_RP_CK, 1'b0, S_IDLE);
                end
              end
              `CLRB_OP_READ: begin
                if (mpr_q || !open_w[bank]) begin
                  err_q <= 1'b1;
                end else if (addr_q[`CLRB_F_AP]) begin
                  // Autoprecharge: hold off until the bank has also recovered.
                  prep(`CLRB_CMD_READ, bank, rd_a, `CLRB_T_CCD_NCK + T_RP_CK, 1'b1,
                       S_IDLE);
                end else begin
                  prep(`CLRB_CMD_READ, bank, rd_a, `CLRB_T_CCD_NCK, 1'b1, S_IDLE);
                end
              end
              `CLRB_OP_MPR_ON: begin
                if (mpr_q) begin
                  err_q <= 1'b1;
                end else begin
                  prep(`CLRB_CMD_PRE, 3'h0, `CLRB_A_ALLBANKS, T_RP_CK, 1'b0,
                       S_MRS_ON);
                end
              end
              `CLRB_OP_MPR_RD: begin
                if (!mpr_q || !dll_s) begin
                  err_q <= 1'b1;
                end else begin
                  prep(`CLRB_CMD_READ, 3'h0, mpr_a, `CLRB_T_CCD_NCK, 1'b1, S_IDLE);
                end
              end
              `CLRB_OP_MPR_OFF: begin
                if (!mpr_q) begin
                  err_q <= 1'b1;
                end else begin
                  st_q <= S_DRAIN;
                end
              end
              default: begin
              end
            endcase
          end
        end
        S_ISSUE: begin
          if (tick) begin
            pcmd_q <= nxt_cmd_q;
            pba_q <= nxt_ba_q;
            pa_q <= nxt_a_q;
            st_q <= S_WAIT;
            if (nxt_cmd_q == `CLRB_CMD_MRS) begin
              mpr_q <= nxt_a_q[`CLRB_F_A2];
            end
          end
        end
        S_WAIT: begin
          if (tick && tm_done) begin
            st_q <= ret_q;
          end
        end
        S_MRS_ON: begin
          prep(`CLRB_CMD_MRS, `CLRB_BA_MR3, mr3_on, T_MODE_CK, 1'b0, S_IDLE);
        end
        S_DRAIN: begin
          if (!rd_busy) begin
            prep(`CLRB_CMD_NOP, 3'h0, 13'h0000, `CLRB_T_MPRR_NCK, 1'b0, S_MRS_OFF);
          end
        end
        S_MRS_OFF: begin
          prep(`CLRB_CMD_MRS, `CLRB_BA_MR3, `CLRB_MR3_OFF, T_MODE_CK, 1'b0,
               S_IDLE);
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  assign DDR_CS_N = pcmd_q[3];
  assign DDR_RAS_N = pcmd_q[2];
  assign DDR_CAS_N = pcmd_q[1];
  assign DDR_WE_N = pcmd_q[0];
  assign DDR_BA = pba_q;
  assign DDR_ADDR = pa_q;

  // Open-row tracking per bank keeps activates and reads legal.
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_bank
      reg open_q;
      wire hit = (nxt_ba_q == b);
      wire is_pre = (nxt_cmd_q == `CLRB_CMD_PRE) && (nxt_a_q[`CLRB_AP_BIT] || hit);
      wire is_rda = nxt_rd_q && !mpr_q && nxt_a_q[`CLRB_AP_BIT] && hit;
      always @(posedge CLK_SYS) begin
        if (RST) begin
          open_q <= 1'b0;
        end else if (iss && (is_pre || is_rda)) begin
          open_q <= 1'b0;
        end else if (iss && hit && nxt_cmd_q == `CLRB_CMD_ACT) begin
          open_q <= 1'b1;
        end
      end
      assign open_w[b] = open_q;
    end
  endgenerate

  // Read capture: the issue is delayed through a shift register in link cycles, so
  // reads spaced by the column spacing produce back-to-back capture windows.
  wire [4:0] rl = cfg_q[`CLRB_F_RL];
  wire start = tick && sr_q[rl];
  wire [2:0] beat = wc_q[4:2];
  wire last = (wc_q == (cur8_q ? `CLRB_LAST8 : `CLRB_LAST4));
  always @(posedge CLK_SYS) begin
    if (RST) begin
      sr_q <= 32'h00000000;
      len_sr_q <= 32'h00000000;
      on_q <= 1'b0;
      cur8_q <= 1'b0;
      wc_q <= 5'h00;
      cap_q <= 16'h0000;
      rdat_q <= 17'h00000;
      valid_q <= 1'b0;
    end else begin
      if (tick) begin
        sr_q <= {sr_q[30:0], iss_rd};
        len_sr_q <= {len_sr_q[30:0], iss_rd & nxt_eight_q};
      end
      if (iss_rd) begin
        valid_q <= 1'b0;
      end
      if (start) begin
        on_q <= 1'b1;
        wc_q <= 5'h01;
        cur8_q <= len_sr_q[rl];
        cap_q[0] <= dq_s[0];
        cap_q[8] <= dq_s[8];
      end else if (on_q) begin
        wc_q <= wc_q + 5'h01;
        if (wc_q[1:0] == `CLRB_BEAT_STEP) begin
          cap_q[{1'b0, beat}] <= dq_s[0];
          cap_q[{1'b1, beat}] <= dq_s[8];
        end
        if (last) begin
          on_q <= 1'b0;
          rdat_q <= {cur8_q, cap_q};
          valid_q <= 1'b1;
        end
      end
    end
  end
endmodule

// ### clrb_map.vh
`ifndef CLRB_MAP_VH
`define CLRB_MAP_VH
`define CLRB_IDX_CMD 6'h00
`define CLRB_IDX_ADDR 6'h01
`define CLRB_IDX_CFG 6'h02
`define CLRB_IDX_STAT 6'h03
`define CLRB_IDX_DATA 6'h04
`define CLRB_OP_NOP 3'h0
`define CLRB_OP_ACT 3'h1
`define CLRB_OP_PRE 3'h2
`define CLRB_OP_PREA 3'h3
`define CLRB_OP_READ 3'h4
`define CLRB_OP_MPR_ON 3'h5
`define CLRB_OP_MPR_RD 3'h6
`define CLRB_OP_MPR_OFF 3'h7
`define CLRB_F_OP 2:0
`define CLRB_F_ROW 12:0
`define CLRB_F_COL 9:0
`define CLRB_F_A2 2
`define CLRB_F_BANK 18:16
`define CLRB_F_BC 20
`define CLRB_F_AP 21
`define CLRB_F_LOC 25:24
`define CLRB_F_RL 4:0
`define CLRB_F_MR0 9:8
`define CLRB_F_RSTN 16
`define CLRB_F_CKE 17
`define CLRB_CFG_RST 32'h00000006
`define CLRB_MR0_FIXED8 2'h0
`define CLRB_MR0_OTF 2'h1
`define CLRB_CMD_NOP 4'h7
`define CLRB_CMD_ACT 4'h3
`define CLRB_CMD_READ 4'h5
`define CLRB_CMD_PRE 4'h2
`define CLRB_CMD_MRS 4'h0
`define CLRB_BA_MR3 3'h3
`define CLRB_MR3_ON 13'h0004
`define CLRB_MR3_OFF 13'h0000
`define CLRB_A_ALLBANKS 13'h0400
`define CLRB_AP_BIT 10
`define CLRB_TICK_PH 3'h3
`define CLRB_CK_NS 320
`define CLRB_T_RP_NS 15
`define CLRB_T_RCD_NS 15
`define CLRB_T_MRD_NCK 8'h04
`define CLRB_T_MOD_NCK 8'h0c
`define CLRB_T_MPRR_NCK 8'h01
`define CLRB_T_CCD_NCK 8'h04
`define CLRB_BEAT_STEP 2'h0
`define CLRB_LAST8 5'h1d
`define CLRB_LAST4 5'h0d
`endif

// ### clrb_sync.v
`timescale 1ns/1ps
module clrb_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      always @(posedge clk) begin
        if (rst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= d[i];
          s2_q <= s1_q;
        end
      end
      assign q[i] = s2_q;
    end
  endgenerate
endmodule

// ### clrb_tmr.v
`timescale 1ns/1ps
module clrb_tmr (
  input wire clk,
  input wire rst,
  input wire load,
  input wire [7:0] val,
  input wire tick,
  output wire done
);
  reg [7:0] cnt_q;
  // The count only moves on command-clock ticks, so a wait is whole link cycles.
  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
    end else if (load) begin
      cnt_q <= val;
    end else if (tick && cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  assign done = (cnt_q == 8'h00);
endmodule

// ### clrb_ctrl_monitor.sv
`timescale 1ns/1ps
module clrb_ctrl_monitor (
  input wire CLK_SYS,
  input wire RST,
  input wire WB_STB_I,
  input wire WB_CYC_I,
  input wire WB_ACK_O,
  input wire DDR_CK,
  input wire DDR_CK_N,
  input wire DDR_CS_N,
  input wire DDR_RAS_N,
  input wire DDR_CAS_N,
  input wire DDR_WE_N,
  input wire [2:0] DDR_BA,
  input wire [12:0] DDR_ADDR,
  input wire DLL_LOCKED
);
  wire [3:0] cmd = {DDR_CS_N, DDR_RAS_N, DDR_CAS_N, DDR_WE_N};
  reg mpr_q;
  // Readout mode as the device sees it, taken from the mode writes on the pins.
  always @(posedge CLK_SYS) begin
    if (RST) mpr_q <= 1'b0;
    else if (cmd == 4'h0 && DDR_BA == 3'h3 && $fell(DDR_CK)) mpr_q <= DDR_ADDR[2];
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  AST_WB_ACK: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack did not follow the request");
  AST_WB_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  AST_CK_PAIR: assert property (DDR_CK_N == !DDR_CK)
    else $error("clock pair not complementary");
  AST_CK_PERIOD: assert property ($rose(DDR_CK) |-> DDR_CK [*4] ##1 !DDR_CK [*4])
    else $error("command clock period wrong");
  AST_CMD_EDGE: assert property ($changed({cmd, DDR_BA, DDR_ADDR}) |-> $fell(DDR_CK))
    else $error("command changed away from falling clock");
  AST_CMD_HOLD: assert property ($fell(DDR_CK) && cmd != 4'h7 |=> $stable(cmd) [*7])
    else $error("command not held one clock");
  AST_NO_WRITE: assert property (cmd != 4'h4)
    else $error("write command issued");
  AST_MPR_ADDR: assert property (mpr_q && cmd == 4'h5 && $fell(DDR_CK) |->
    DDR_ADDR[1:0] == 2'h0 && !(DDR_ADDR[12] && DDR_ADDR[2]))
    else $error("calibration read address wrong");
  AST_MPR_ONLY: assert property (mpr_q && $fell(DDR_CK) && cmd != 4'h7 |->
    cmd == 4'h5 || cmd == 4'h0)
    else $error("other command in readout mode");
  AST_MPR_DLL: assert property (mpr_q && cmd == 4'h5 && $fell(DDR_CK) |-> DLL_LOCKED)
    else $error("calibration read without lock");
endmodule
bind clrb_ctrl clrb_ctrl_monitor clrb_ctrl_monitor_inst (.*);

// ### clrb_dev_model.sv
`timescale 1ns/1ps
module clrb_dev_model (
  input wire ck,
  input wire [3:0] cmd,
  input wire [2:0] ba,
  input wire [12:0] a,
  input wire [4:0] rl,
  input wire [1:0] mr0,
  input wire dll,
  output logic [15:0] dq,
  output int errs
);
  logic [12:0] row [8];
  logic [7:0] open_b = 8'h00;
  logic calibration_pattern_register = 1'b0;
  logic [1:0] loc = 2'h0;
  logic chop;
  int act = 0;
  int t_pre = 9;
  int t_mrs = 99;
  int t_rd = 99;
  initial begin
    dq = 16'h5a5a;
    errs = 0;
  end
  // Idle lines flip every half clock, so a stale sample never looks like data.
  always @(ck) #1 if (act == 0) dq = ~dq;
  task automatic burst(input logic [7:0] p, input logic [7:0] u, input int n, input int s);
    repeat (rl) @(posedge ck);
    act++;
    for (int k = s; k < s + n; k++) begin
      if (k != s) @(ck);
      dq = {{8{u[k]}}, {8{p[k]}}};
    end
    @(ck);
    act--;
  endtask
  always @(posedge ck) begin
    t_pre++;
    t_mrs++;
    t_rd++;
    chop = mr0 == 2'h2 || (mr0 == 2'h1 && !a[12]);
    case (cmd)
      4'h3: begin
        if (calibration_pattern_register || open_b[ba] || t_pre < 1) errs++;
        open_b[ba] = 1'b1;
        row[ba] = a;
      end
      4'h2: begin
        if (calibration_pattern_register) errs++;
        if (a[10]) open_b = 8'h00; else open_b[ba] = 1'b0;
        t_pre = 0;
      end
      4'h0: if (ba == 3'h3) begin
        if (a[2] && (open_b != 8'h00 || t_pre < 1)) errs++;
        if (!a[2] && t_rd < rl + 5) errs++;
        calibration_pattern_register = a[2];
        loc = a[1:0];
        t_mrs = 0;
      end
      4'h5: begin
        if (t_mrs < 12) errs++;
        t_rd = 0;
        if (calibration_pattern_register) begin
          if (a[1:0] != 2'h0 || (!chop && a[2]) || !dll) errs++;
          fork
            burst(loc == 2'h0 ? 8'haa : 8'h00, loc == 2'h0 ? 8'haa : 8'h00,
              chop ? 4 : 8, (chop && a[2]) ? 4 : 0);
          join_none
        end else begin
          if (!open_b[ba]) errs++;
          fork
            burst(row[ba][7:0], ~row[ba][7:0], chop ? 4 : 8, 0);
          join_none
          if (a[10]) open_b[ba] = 1'b0;
        end
      end
      4'h7: ;
      default: if (!cmd[3]) errs++;
    endcase
  end
endmodule

// ### clrb_ctrl_bench.sv
`timescale 1ns/1ps
module clrb_ctrl_bench;
  logic CLK_SYS = 0, RST = 1, WB_WE_I = 0, WB_STB_I = 0, WB_CYC_I = 0, DLL_LOCKED = 0;
  logic [7:0] WB_ADR_I = 0;
  logic [31:0] WB_DAT_I = 0;
  logic [3:0] WB_SEL_I = 0;
  wire [31:0] WB_DAT_O;
  wire WB_ACK_O, DDR_CK, DDR_CK_N, DDR_CKE, DDR_RESET_N;
  wire DDR_CS_N, DDR_RAS_N, DDR_CAS_N, DDR_WE_N;
  wire [2:0] DDR_BA;
  wire [12:0] DDR_ADDR;
  wire [15:0] DDR_DQ;
  int errs, bad_count = 0, n_compared = 0;
  logic [31:0] rd;
  logic [12:0] row;
  logic [2:0] bank;
  logic [4:0] rl = 5'd6;
  logic [1:0] mr0 = 2'h0;
  logic e, bc;
  always #20 CLK_SYS = ~CLK_SYS;
  clrb_ctrl clrb_ctrl_inst (.*);
  clrb_dev_model clrb_dev_model_inst (.ck(DDR_CK), .cmd({DDR_CS_N, DDR_RAS_N, DDR_CAS_N, DDR_WE_N}),
    .ba(DDR_BA), .a(DDR_ADDR), .rl(rl), .mr0(mr0), .dll(DLL_LOCKED), .dq(DDR_DQ), .errs(errs));
  task results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk_val(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    n_compared++;
    if ((got & m) !== (exp & m)) begin
      bad_count++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task chk_err(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t refusal flag %b expected %b", $time, got, exp);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    WB_CYC_I <= 1;
    WB_STB_I <= 1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    WB_SEL_I <= 4'hf;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 100);
    if (n >= 100) chk_err(1'b1, 1'b0);
    rd = WB_DAT_O;
    WB_CYC_I <= 0;
    WB_STB_I <= 0;
    @(posedge CLK_SYS);
  endtask
  task op(input logic [2:0] o, input logic [31:0] a);
    int n;
    n = 0;
    wb(1, 8'h04, a);
    wb(1, 8'h00, {29'h0, o});
    do begin
      wb(0, 8'h0c, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 400);
    if (n >= 400) chk_err(1'b1, 1'b0);
    e = rd[3];
  endtask
  // Read data lands well after busy falls, so wait for the valid flag first.
  task rdata;
    int n;
    n = 0;
    do begin
      wb(0, 8'h0c, 32'h0);
      n++;
    end while (rd[4] !== 1'b1 && n < 400);
    if (n >= 400) chk_err(1'b1, 1'b0);
    wb(0, 8'h10, 0);
  endtask
  function logic [31:0] ad(input logic ap, input logic b, input logic [2:0] k, input logic a2);
    return {8'h0, 2'h0, ap, b, 1'b0, k, 13'h0, a2, 2'h0};
  endfunction
  task cfg;
    wb(1, 8'h08, {14'h0, 2'b11, 6'h0, mr0, 3'h0, rl});
  endtask
  initial begin
    #3000000;
    chk_err(1'b1, 1'b0);
    results;
  end
  initial begin
    void'($urandom(63420));
    rl = 5'd5 + 5'($urandom_range(3));
    row = 13'($urandom);
    bank = 3'($urandom);
    repeat (5) @(posedge CLK_SYS);
    RST <= 0;
    wb(0, 8'h08, 0);
    chk_val(rd, 32'h00000006, 32'h0003031f);
    cfg;
    wb(0, 8'h3c, 0);
    chk_val(rd, 32'h0, 32'hffffffff);
    op(3'h6, 0);
    chk_err(e, 1'b1);
    op(3'h4, ad(0, 1, bank, 0));
    chk_err(e, 1'b1);
    op(3'h1, {13'h0, bank, 3'h0, row});
    chk_err(e, 1'b0);
    op(3'h1, {13'h0, bank, 3'h0, row});
    chk_err(e, 1'b1);
    // Fixed eight, on-the-fly chop, on-the-fly eight, fixed chop with autoprecharge.
    for (int i = 0; i < 4; i++) begin
      mr0 = (i == 0) ? 2'h0 : (i == 3) ? 2'h2 : 2'h1;
      bc = (i != 1);
      cfg;
      op(3'h4, ad(i == 3, bc, bank, 0));
      rdata;
      if (i == 0 || i == 2) chk_val(rd, {15'h1, ~row[7:0], row[7:0]}, 32'h1ffff);
      else chk_val(rd, {15'h0, 4'h0, ~row[3:0], 4'h0, row[3:0]}, 32'h10f0f);
    end
    op(3'h4, ad(0, 1, bank, 0));
    chk_err(e, 1'b1);
    op(3'h2, {13'h0, bank, 16'h0});
    chk_err(e, 1'b0);
    op(3'h5, 0);
    chk_err(e, 1'b0);
    op(3'h6, 0);
    chk_err(e, 1'b1);
    DLL_LOCKED <= 1;
    op(3'h1, {13'h0, bank, 3'h0, row});
    chk_err(e, 1'b1);
    mr0 = 2'h1;
    cfg;
    for (int j = 0; j < 6; j++) begin
      op(3'h6, ad(1'($urandom), j % 3 == 0, 3'($urandom), j % 3 == 2));
      chk_err(e, 1'b0);
      rdata;
      if (j % 3 == 0) chk_val(rd, 32'h1aaaa, 32'h1ffff);
      else chk_val(rd, 32'h00a0a, 32'h10f0f);
    end
    op(3'h7, 0);
    wb(0, 8'h0c, 0);
    chk_val(rd, 32'h0, 32'h2);
    op(3'h1, {13'h0, bank, 3'h0, ~row});
    chk_err(e, 1'b0);
    chk_val(32'(errs), 32'h0, 32'hffffffff);
    results;
  end
endmodule
